// File: verilog/usb_phy_control_reg.sv
// Purpose: Transceiver control register with line filter and resume flags
// Assumes: Inputs synchronous to core_clk; single word AHB-Lite transfers
// Notes:   Zero wait states; response always OKAY
//
// Functional notes
// - Pulldown disable bit turns off port pulldowns
// - Reset-signalling auto-resume sets SE0 cause flag
// - Resume-signalling auto-resume sets K cause flag
// - Line change held two-to-filter-field clocks
// - Resume enable lets hardware resume from suspend
// - Config field drives three transceiver pins
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module usb_phy_control_reg
(
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic [1:0]                    lineStateRaw,
    input  wire logic                          suspended,
    output logic      [1:0]                    lineStateFilt,
    output logic                               resumeReq,
    output usb_phy_ctrl_pkg::phy_pins_t        phyPins,
    output logic                               irq
);

    logic [31:0]                          control;
    logic [usb_phy_ctrl_pkg::IRQ_W-1:0]   irqStat;
    logic [usb_phy_ctrl_pkg::IRQ_W-1:0]   irqEn;
    logic                                 wrPending;
    logic [7:0]                           wrAddr;
    logic [15:0]                          filtCount;
    logic [1:0]                           lineCand;
    logic                                 se0Event;
    logic                                 kEvent;
    logic                                 changeEvent;
    logic                                 accept;
    logic [3:0]                           filtSel;
    logic [15:0]                          filtLimit;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    assign accept    = hsel && hready && htrans == usb_phy_ctrl_pkg::HTRANS_NONSEQ;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPending <= 1'b0;
            wrAddr    <= 8'h00;
        end
        else
        begin
            wrPending <= accept && hwrite && hsize == usb_phy_ctrl_pkg::HSIZE_WORD;
            wrAddr    <= haddr[7:0];
        end
    end

    // Reads sampled in address phase; unmapped reads give zero
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            hrdata <= 32'h0000_0000;
        else if (accept && !hwrite)
        begin
            case (haddr[7:0])
                usb_phy_ctrl_pkg::OFF_CONTROL:  hrdata <= control;
                usb_phy_ctrl_pkg::OFF_LINE:     hrdata <= 32'(lineStateFilt);
                usb_phy_ctrl_pkg::OFF_IRQ_STAT: hrdata <= 32'(irqStat);
                usb_phy_ctrl_pkg::OFF_IRQ_EN:   hrdata <= 32'(irqEn);
                default:                        hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control word
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            control <= usb_phy_ctrl_pkg::CONTROL_RESET;
        else
        begin
            if (wrPending && wrAddr == usb_phy_ctrl_pkg::OFF_CONTROL)
            begin
                control <= hwdata & usb_phy_ctrl_pkg::CONTROL_WMASK;
                // Flags clear only by writing zero
                control[usb_phy_ctrl_pkg::BIT_SE0_CAUSE] <= control[usb_phy_ctrl_pkg::BIT_SE0_CAUSE]
                    & hwdata[usb_phy_ctrl_pkg::BIT_SE0_CAUSE];
                control[usb_phy_ctrl_pkg::BIT_K_CAUSE] <= control[usb_phy_ctrl_pkg::BIT_K_CAUSE]
                    & hwdata[usb_phy_ctrl_pkg::BIT_K_CAUSE];
            end
            // Set after clear so the event wins
            if (se0Event)
                control[usb_phy_ctrl_pkg::BIT_SE0_CAUSE] <= 1'b1;
            if (kEvent)
                control[usb_phy_ctrl_pkg::BIT_K_CAUSE] <= 1'b1;
        end
    end

    // One driver for the whole carrier
    assign phyPins = '{
        pulldownDisable:       control[usb_phy_ctrl_pkg::BIT_PD_DISABLE],
        resumeEnable:          control[usb_phy_ctrl_pkg::BIT_RESUME_EN],
        transceiverConfigPins: control[usb_phy_ctrl_pkg::CONF_LSB +: usb_phy_ctrl_pkg::CONF_W]
    };

    ////////////////////////////////////////////////////////////////////////
    // Line state filter
    assign filtSel   = control[usb_phy_ctrl_pkg::FILT_LSB +: usb_phy_ctrl_pkg::FILT_W];
    assign filtLimit = 16'h0001 << filtSel;

    // Candidate must stay stable for 2^n clocks before it is passed on
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lineCand      <= usb_phy_ctrl_pkg::LINE_J;
            lineStateFilt <= usb_phy_ctrl_pkg::LINE_J;
            filtCount     <= 16'h0000;
        end
        else if (lineStateRaw != lineCand)
        begin
            lineCand  <= lineStateRaw;
            filtCount <= 16'h0001;
        end
        else if (lineCand != lineStateFilt)
        begin
            if (filtCount >= filtLimit)
                lineStateFilt <= lineCand;
            else
                filtCount <= filtCount + 16'h0001;
        end
    end

    assign changeEvent = lineCand != lineStateFilt && lineStateRaw == lineCand && filtCount >= filtLimit;

    ////////////////////////////////////////////////////////////////////////
    // Auto-resume: only while suspended and enabled
    assign se0Event = changeEvent && suspended && phyPins.resumeEnable
                      && lineCand == usb_phy_ctrl_pkg::LINE_SE0;
    assign kEvent   = changeEvent && suspended && phyPins.resumeEnable
                      && lineCand == usb_phy_ctrl_pkg::LINE_K;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            resumeReq <= 1'b0;
        else
            resumeReq <= se0Event || kEvent;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irqEn <= '0;
        else if (wrPending && wrAddr == usb_phy_ctrl_pkg::OFF_IRQ_EN)
            irqEn <= hwdata[usb_phy_ctrl_pkg::IRQ_W-1:0];
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irqStat <= '0;
        else
        begin
            if (wrPending && wrAddr == usb_phy_ctrl_pkg::OFF_IRQ_CLR)
                irqStat <= irqStat & ~hwdata[usb_phy_ctrl_pkg::IRQ_W-1:0];
            if (se0Event)
                irqStat[usb_phy_ctrl_pkg::IRQ_SE0] <= 1'b1;
            if (kEvent)
                irqStat[usb_phy_ctrl_pkg::IRQ_K] <= 1'b1;
            if (changeEvent)
                irqStat[usb_phy_ctrl_pkg::IRQ_CHANGE] <= 1'b1;
        end
    end

    assign irq = |(irqStat & irqEn);

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_flagWrite(int b);
        wrPending && wrAddr == usb_phy_ctrl_pkg::OFF_CONTROL && hwdata[b];
    endsequence

    a_pulldown_pin: assert property (@(posedge core_clk) disable iff (!nrst)
        wrPending && wrAddr == usb_phy_ctrl_pkg::OFF_CONTROL
        |=> phyPins.pulldownDisable == $past(hwdata[usb_phy_ctrl_pkg::BIT_PD_DISABLE]))
        else $error("Pulldown pin does not follow write");

    a_se0_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
        se0Event |=> control[usb_phy_ctrl_pkg::BIT_SE0_CAUSE])
        else $error("SE0 cause flag not set");

    a_k_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
        kEvent |=> control[usb_phy_ctrl_pkg::BIT_K_CAUSE])
        else $error("K cause flag not set");

    a_filter_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(lineStateFilt) |-> $past(filtCount) >= $past(filtLimit))
        else $error("Line state passed before filter delay");

    a_resume_gate: assert property (@(posedge core_clk) disable iff (!nrst)
        resumeReq |-> $past(phyPins.resumeEnable) && $past(suspended))
        else $error("Resume without enable or suspend");

    a_config_pins: assert property (@(posedge core_clk) disable iff (!nrst)
        wrPending && wrAddr == usb_phy_ctrl_pkg::OFF_CONTROL
        |=> phyPins.transceiverConfigPins == $past(hwdata[usb_phy_ctrl_pkg::CONF_LSB +: usb_phy_ctrl_pkg::CONF_W]))
        else $error("Config pins do not follow write");

    a_flag_one_keeps: assert property (@(posedge core_clk) disable iff (!nrst)
        s_flagWrite(usb_phy_ctrl_pkg::BIT_SE0_CAUSE) ##0 (!control[usb_phy_ctrl_pkg::BIT_SE0_CAUSE] && !se0Event)
        |=> !control[usb_phy_ctrl_pkg::BIT_SE0_CAUSE])
        else $error("Writing one set the SE0 cause flag");

    a_set_beats_clr: assert property (@(posedge core_clk) disable iff (!nrst)
        kEvent && wrPending && wrAddr == usb_phy_ctrl_pkg::OFF_CONTROL |=> control[usb_phy_ctrl_pkg::BIT_K_CAUSE])
        else $error("Clear beat hardware set");

endmodule

// File: verilog/usb_phy_ctrl_pkg.sv
// Purpose: Constants and carriers for the transceiver control register bank
// Assumes: AHB-Lite slave, 32-bit data, word registers
// Notes:   Interrupt registers sit beside the control word
package usb_phy_ctrl_pkg;

    localparam logic [7:0] OFF_CONTROL  = 8'h40;
    localparam logic [7:0] OFF_LINE     = 8'h44;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h48;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h4C;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h50;

    localparam int BIT_PD_DISABLE = 18;
    localparam int BIT_SE0_CAUSE  = 13;
    localparam int BIT_K_CAUSE    = 12;
    localparam int FILT_LSB       = 8;
    localparam int FILT_W         = 4;
    localparam int BIT_RESUME_EN  = 7;
    localparam int CONF_LSB       = 4;
    localparam int CONF_W         = 3;

    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_WMASK = 32'h0004_3FF0;

    localparam int IRQ_SE0    = 0;
    localparam int IRQ_K      = 1;
    localparam int IRQ_CHANGE = 2;
    localparam int IRQ_W      = 3;

    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_J   = 2'h1;
    localparam logic [1:0] LINE_K   = 2'h2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef struct packed {
        logic       pulldownDisable;
        logic       resumeEnable;
        logic [2:0] transceiverConfigPins;
    } phy_pins_t;

endpackage

// File: bench/usb_xcvr_model.sv
// Purpose: Transceiver stand-in for line state and suspend
// Assumes: Bench commands it in the core_clk domain
// Notes:   Line idles at J; one clock of pad delay
`timescale 1ns/1ps
module usb_xcvr_model
(
    input  wire logic       core_clk,
    input  wire logic [1:0] lineCmd,
    input  wire logic       suspendCmd,
    output logic      [1:0] lineStateRaw,
    output logic            suspended
);
    // Registered so the line never moves on the bench's own edge
    always @(posedge core_clk)
    begin
        lineStateRaw <= lineCmd;
        suspended    <= suspendCmd;
    end
endmodule

// File: bench/usb_phy_control_reg_test.sv
// Purpose: Self-checking bench for the transceiver control register
// Assumes: One zero wait-state slave, single word transfers
// Notes:   Filter field 2 keeps line tests to a few clocks
`timescale 1ns/1ps
module usb_phy_control_reg_test;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  lineCmd = 2'h1;
    logic        suspendCmd = 1'b0;
    logic [1:0]  lineStateRaw;
    logic        suspended;
    logic [1:0]  lineStateFilt;
    logic        resumeReq;
    logic        irq;
    int          errors = 0;
    int          comparisons = 0;
    int          pulses = 0;
    integer      seed = 32'h982E;
    logic [31:0] expQ[$];
    logic [31:0] gotQ[$];
    string       nameQ[$];
    event        gotEv;
    usb_phy_ctrl_pkg::phy_pins_t phyPins;
    ////////////////////////////////////////////////////////////////////////////
    usb_phy_control_reg usb_phy_control_reg_inst (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lineStateRaw(lineStateRaw), .suspended(suspended),
        .lineStateFilt(lineStateFilt), .resumeReq(resumeReq), .phyPins(phyPins), .irq(irq));
    usb_xcvr_model usb_xcvr_model_inst (.core_clk(core_clk), .lineCmd(lineCmd), .suspendCmd(suspendCmd),
        .lineStateRaw(lineStateRaw), .suspended(suspended));
    initial
        forever #4 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (resumeReq === 1'b1)
            pulses++;
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic note(input string name, input logic [31:0] exp, input logic [31:0] got);
        nameQ.push_back(name);
        expQ.push_back(exp);
        gotQ.push_back(got);
        -> gotEv;
    endtask
    initial
        forever
        begin
            @(gotEv);
            while (gotQ.size() > 0)
                chk(nameQ.pop_front(), expQ.pop_front(), gotQ.pop_front());
        end
    task automatic tick(input logic hit, input int n);
        if (n >= 64)
        begin
            errors++;
            final_report();
        end
    endtask
    task automatic waitReady;
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        tick(1'b1, n);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= usb_phy_ctrl_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= usb_phy_ctrl_pkg::HSIZE_WORD;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        note(name, exp, q);
    endtask
    task automatic lineTo(input logic [1:0] v, output int n);
        lineCmd <= v;
        n = 0;
        while (lineStateFilt !== v && n < 64)
        begin
            @(posedge core_clk);
            n++;
        end
        tick(1'b1, n);
        repeat (3) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] v;
        int n;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        rd("ctrl", 8'h40, 32'h0);
        rd("line", 8'h44, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            v = ($random(seed) & ~32'h70) | (32'(i) << 4);
            wr(8'h40, v);
            rd("ctrl", 8'h40, v & usb_phy_ctrl_pkg::CONTROL_WMASK & 32'hFFFF_CFFF);
            note("pins", {27'h0, v[18], v[7], v[6:4]}, {27'h0, phyPins});
        end
        wr(8'h50, 32'h7);
        wr(8'h40, 32'h280);
        suspendCmd <= 1'b1;
        lineCmd <= usb_phy_ctrl_pkg::LINE_K;
        repeat (2) @(posedge core_clk);
        lineCmd <= usb_phy_ctrl_pkg::LINE_J;
        repeat (8) @(posedge core_clk);
        note("glitch", 32'h1, {30'h0, lineStateFilt});
        lineTo(usb_phy_ctrl_pkg::LINE_K, n);
        note("delay", 32'h1, {31'h0, n >= 4 && n <= 8});
        note("pulses", 32'h1, pulses);
        note("irq", 32'h1, {31'h0, irq});
        rd("ctrl", 8'h40, 32'h1280);
        wr(8'h40, 32'h1280);
        rd("ctrl", 8'h40, 32'h1280);
        wr(8'h40, 32'h280);
        rd("ctrl", 8'h40, 32'h280);
        lineTo(usb_phy_ctrl_pkg::LINE_J, n);
        lineTo(usb_phy_ctrl_pkg::LINE_SE0, n);
        rd("ctrl", 8'h40, 32'h2280);
        rd("status", 8'h48, 32'h7);
        wr(8'h4C, 32'h7);
        rd("status", 8'h48, 32'h0);
        note("irq", 32'h0, {31'h0, irq});
        wr(8'h40, 32'h200);
        lineTo(usb_phy_ctrl_pkg::LINE_K, n);
        note("pulses", 32'h2, pulses);
        rd("ctrl", 8'h40, 32'h200);
        wr(8'h50, 32'h0);
        @(posedge core_clk);
        note("irq", 32'h0, {31'h0, irq});
        wr(8'h50, 32'h4);
        @(posedge core_clk);
        note("irq", 32'h1, {31'h0, irq});
        wr(8'h40, 32'h280);
        lineTo(usb_phy_ctrl_pkg::LINE_J, n);
        // Clear write lands on the edge that the filter passes K on
        lineCmd <= usb_phy_ctrl_pkg::LINE_K;
        repeat (4) @(posedge core_clk);
        wr(8'h40, 32'h280);
        rd("ctrl", 8'h40, 32'h1280);
        note("pulses", 32'h3, pulses);
        // Mid-run reset must bring back reset values
        nrst <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        rd("line", 8'h44, 32'h1);
        rd("ctrl", 8'h40, 32'h0);
        rd("unmapped", 8'h60, 32'h0);
        note("hresp", 32'h0, {31'h0, hresp});
        @(posedge core_clk);
        final_report();
    end
endmodule
